// *** design/can_rx_fifo_status.sv ***
// What this block does
// - keep two-bit fifo 0 message count, add one per stored message
// - release of fifo 0 output mailbox lowers its count by one
// - fifo 0 full flag set at three messages, cleared by writing one
// - store into full fifo 0 sets overrun flag, cleared by writing one
// - writing one to fifo 0 release bit frees mailbox; ignored when empty
// - keep two-bit fifo 1 message count, add one per stored message
// - release of fifo 1 output mailbox lowers its count by one
// - fifo 1 full flag set at three messages, cleared by writing one
// - store into full fifo 1 sets overrun flag, cleared by writing one
// - writing one to fifo 1 release bit frees mailbox; ignored when empty
// - interrupt when a fifo count is nonzero and pending enable set
// - interrupt when a fifo full flag and its enable are set
// - interrupt when a fifo overrun flag and its enable are set
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module can_rx_fifo_status (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // receive path
  input wire logic RX0_STORE,
  input wire logic RX1_STORE,
  output logic RX0_RELEASE,
  output logic RX1_RELEASE,
  // axi4-lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // interrupt
  output logic IRQ
);
  import rxf_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    wreq_type wreq;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] irq_en;
    logic [5:0] sts;
  } state_type;

  state_type s_r, s_nxt;
  fifo_state_type f0, f1;
  logic [5:0] ev;
  logic wr_go, wr_lane0;
  logic rel0_wr, rel1_wr, full0_clr, full1_clr, ovr0_clr, ovr1_clr;
  logic pend0_ev, pend1_ev;

  // fifo register image, reserved bits read zero
  function automatic logic [31:0] fifo_word(input fifo_state_type f);
    logic [31:0] w;
    w = 32'h0;
    w[CNT_LSB +: 2] = f.count;
    w[FULL_BIT] = f.full;
    w[OVR_BIT] = f.overrun;
    w[REL_BIT] = f.release_pend;
    return w;
  endfunction

  // is an address one of ours
  function automatic logic mapped(input logic [7:0] a);
    return a == RXF0_OFFSET || a == RXF1_OFFSET || a == IRQ_EN_OFFSET ||
      a == IRQ_STS_OFFSET || a == IRQ_CLR_OFFSET;
  endfunction

  // write fires once address and data are both held and no response waits
  assign wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_lane0 = wr_go && s_r.wreq.strb[0];

  assign rel0_wr = wr_lane0 && s_r.wreq.addr == RXF0_OFFSET &&
    s_r.wreq.data[REL_BIT];
  assign rel1_wr = wr_lane0 && s_r.wreq.addr == RXF1_OFFSET &&
    s_r.wreq.data[REL_BIT];
  assign full0_clr = wr_lane0 && s_r.wreq.addr == RXF0_OFFSET &&
    s_r.wreq.data[FULL_BIT];
  assign full1_clr = wr_lane0 && s_r.wreq.addr == RXF1_OFFSET &&
    s_r.wreq.data[FULL_BIT];
  assign ovr0_clr = wr_lane0 && s_r.wreq.addr == RXF0_OFFSET &&
    s_r.wreq.data[OVR_BIT];
  assign ovr1_clr = wr_lane0 && s_r.wreq.addr == RXF1_OFFSET &&
    s_r.wreq.data[OVR_BIT];

  rx_fifo_track u_fifo0 (
    .clk(SYS_CLK),
    .srst(SRST),
    .store(RX0_STORE),
    .rel_wr(rel0_wr),
    .full_clr(full0_clr),
    .ovr_clr(ovr0_clr),
    .st(f0),
    .pend_event(pend0_ev)
  );

  rx_fifo_track u_fifo1 (
    .clk(SYS_CLK),
    .srst(SRST),
    .store(RX1_STORE),
    .rel_wr(rel1_wr),
    .full_clr(full1_clr),
    .ovr_clr(ovr1_clr),
    .st(f1),
    .pend_event(pend1_ev)
  );

  // events gathered in interrupt enable layout order, bits 0..5
  // a store that refills a slot freed in the same cycle is no event
  assign ev = {RX1_STORE && !RX1_RELEASE && f1.count == FIFO_DEPTH,
    RX1_STORE && !RX1_RELEASE && f1.count == 2'h2, pend1_ev,
    RX0_STORE && !RX0_RELEASE && f0.count == FIFO_DEPTH,
    RX0_STORE && !RX0_RELEASE && f0.count == 2'h2, pend0_ev};

  always_comb begin
    s_nxt = s_r;
    // address channel
    if (AWVALID && AWREADY) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.wreq.addr = AWADDR;
    end
    // data channel
    if (WVALID && WREADY) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wreq.data = WDATA;
      s_nxt.wreq.strb = WSTRB;
    end
    // response handshake
    if (s_r.bvalid && BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    // perform write
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.wreq.addr) ? RESP_OKAY : RESP_SLVERR;
      if (s_r.wreq.addr == IRQ_EN_OFFSET && s_r.wreq.strb[0]) begin
        s_nxt.irq_en = s_r.wreq.data[6:0];
      end
      if (s_r.wreq.addr == IRQ_CLR_OFFSET && s_r.wreq.strb[0]) begin
        s_nxt.sts = s_r.sts & ~s_r.wreq.data[5:0];
      end
    end
    // sticky events, set wins over clear
    s_nxt.sts = s_nxt.sts | ev;
    // read channel
    if (s_r.rvalid && RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      unique case (ARADDR)
        RXF0_OFFSET: s_nxt.rdata = fifo_word(f0);
        RXF1_OFFSET: s_nxt.rdata = fifo_word(f1);
        IRQ_EN_OFFSET: s_nxt.rdata = {25'h0, s_r.irq_en};
        IRQ_STS_OFFSET: s_nxt.rdata = {26'h0, s_r.sts};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // register the whole state
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_r <= '0;
      s_r.irq_en <= IRQ_EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // channels accept one item each while their own previous item is not pending
  assign AWREADY = !s_r.aw_got;
  assign WREADY = !s_r.w_got;
  assign ARREADY = !s_r.rvalid;
  assign BVALID = s_r.bvalid;
  assign BRESP = s_r.bresp;
  assign RVALID = s_r.rvalid;
  assign RDATA = s_r.rdata;
  assign RRESP = s_r.rresp;

  // only oldest message shown; release strobe to storage
  assign RX0_RELEASE = f0.release_pend && f0.count != 2'h0;
  assign RX1_RELEASE = f1.release_pend && f1.count != 2'h0;

  // level interrupt from live fifo state
  always_comb begin
    IRQ = (s_r.irq_en[PEND0_EN_BIT] && f0.count != 2'h0) ||
      (s_r.irq_en[PEND1_EN_BIT] && f1.count != 2'h0);
    IRQ = IRQ || (s_r.irq_en[FULL0_EN_BIT] && f0.full) ||
      (s_r.irq_en[FULL1_EN_BIT] && f1.full);
    IRQ = IRQ || (s_r.irq_en[OVR0_EN_BIT] && f0.overrun) ||
      (s_r.irq_en[OVR1_EN_BIT] && f1.overrun);
  end
endmodule // can_rx_fifo_status
`default_nettype wire

// *** design/rxf_pkg.sv ***
`default_nettype none
package rxf_pkg;
  // register byte offsets
  localparam logic [7:0] RXF0_OFFSET = 8'h0c;
  localparam logic [7:0] RXF1_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h14;
  localparam logic [7:0] IRQ_STS_OFFSET = 8'h20;
  localparam logic [7:0] IRQ_CLR_OFFSET = 8'h24;
  // fifo register fields
  localparam int CNT_LSB = 0;
  localparam int FULL_BIT = 3;
  localparam int OVR_BIT = 4;
  localparam int REL_BIT = 5;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  // interrupt enable fields
  localparam int PEND0_EN_BIT = 1;
  localparam int FULL0_EN_BIT = 2;
  localparam int OVR0_EN_BIT = 3;
  localparam int PEND1_EN_BIT = 4;
  localparam int FULL1_EN_BIT = 5;
  localparam int OVR1_EN_BIT = 6;
  localparam logic [6:0] IRQ_EN_RESET = 7'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // state of one receive fifo
  typedef struct packed {
    logic [1:0] count;
    logic full;
    logic overrun;
    logic release_pend;
  } fifo_state_type;

  // write request towards the registers
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wreq_type;
endpackage : rxf_pkg
`default_nettype wire

// *** design/rx_fifo_track.sv ***
`default_nettype none
module rx_fifo_track (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // receive path store strobe
  input wire logic store,
  // software side, one-cycle strobes
  input wire logic rel_wr,
  input wire logic full_clr,
  input wire logic ovr_clr,
  // state
  output rxf_pkg::fifo_state_type st,
  output logic pend_event
);
  import rxf_pkg::*;

  fifo_state_type st_r, st_nxt;
  logic do_rel;

  // release phase: pending request takes effect one cycle after write
  always_comb begin
    st_nxt = st_r;
    do_rel = st_r.release_pend && (st_r.count != 2'h0);
    st_nxt.release_pend = rel_wr;
    // count down on release, count up on store
    // store and release together leave the count alone, even when full
    if (store && !do_rel && (st_r.count != FIFO_DEPTH)) begin
      st_nxt.count = st_r.count + 2'h1;
    end else if (do_rel && !store) begin
      st_nxt.count = st_r.count - 2'h1;
    end
    // full flag, set wins over clear
    if (full_clr) begin
      st_nxt.full = 1'b0;
    end
    if (st_nxt.count == FIFO_DEPTH && st_r.count != FIFO_DEPTH) begin
      st_nxt.full = 1'b1;
    end
    if (ovr_clr) begin
      st_nxt.overrun = 1'b0;
    end
    if (store && st_r.count == FIFO_DEPTH && !do_rel) begin
      st_nxt.overrun = 1'b1;
    end
  end

  // store while full with a release in the same cycle replaces the slot
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign st = st_r;
  assign pend_event = (st_r.count == 2'h0) && (st_nxt.count != 2'h0);
endmodule // rx_fifo_track
`default_nettype wire

// *** verif/can_rx_fifo_status_properties.sv ***
`default_nettype none
module can_rx_fifo_status_properties (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  // receive path and interrupt
  input wire logic RX0_STORE,
  input wire logic RX1_STORE,
  input wire logic RX0_RELEASE,
  input wire logic RX1_RELEASE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // release strobes are single cycle and follow a write
  chk_rel0_pulse:
    assert property (RX0_RELEASE |=> !RX0_RELEASE) else $error("rel0 long");
  chk_rel1_pulse:
    assert property (RX1_RELEASE |=> !RX1_RELEASE) else $error("rel1 long");
  chk_rel0_cause:
    assert property (RX0_RELEASE |-> BVALID || $past(BVALID))
      else $error("rel0 without write");
  chk_rel1_cause:
    assert property (RX1_RELEASE |-> BVALID || $past(BVALID))
      else $error("rel1 without write");
  // enables start cleared, so no interrupt right after reset
  chk_irq_reset:
    assert property ($fell(SRST) |-> !IRQ) else $error("irq after reset");
  // a rising interrupt needs a store or a register write
  chk_irq_cause:
    assert property ($rose(IRQ) |-> BVALID || $past(RX0_STORE || RX1_STORE))
      else $error("irq without cause");
  chk_write_answer:
    assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
      else $error("no write response");
  chk_read_answer:
    assert property (ARVALID && ARREADY |=> RVALID) else $error("no read data");
endmodule // can_rx_fifo_status_properties
bind can_rx_fifo_status can_rx_fifo_status_properties
  can_rx_fifo_status_properties_i (.*);
`default_nettype wire

// *** verif/can_rx_path_model.sv ***
`default_nettype none
module can_rx_path_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // release strobes from the block
  input wire logic rel0,
  input wire logic rel1,
  // store strobes towards the block
  output logic store0,
  output logic store1
);
  timeunit 1ns;
  timeprecision 1ns;
  int rel_n[2];
  initial {store1, store0} = 2'b00;
  // count freed mailboxes
  // the path does not wait for a release before it sends the next message
  always @(posedge clk) begin
    if (srst)
      rel_n = '{0, 0};
    if (rel0)
      rel_n[0]++;
    if (rel1)
      rel_n[1]++;
  end
  // one-cycle strobe per accepted message
  task automatic store(input int f);
    @(posedge clk);
    if (f == 0)
      store0 <= 1'b1;
    else
      store1 <= 1'b1;
    @(posedge clk);
    {store1, store0} <= 2'b00;
  endtask
endmodule // can_rx_path_model
`default_nettype wire

// *** verif/can_rx_fifo_status_tb.sv ***
`default_nettype none
module can_rx_fifo_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rxf_pkg::*;
  logic clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, a;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  wire logic st0, st1, rel0, rel1, awready, wready, bvalid, arready;
  wire logic rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int bad_count = 0, checks_done = 0, s;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  always #10 clk = ~clk;
  can_rx_fifo_status can_rx_fifo_status_i (.SYS_CLK(clk), .SRST(srst),
    .RX0_STORE(st0), .RX1_STORE(st1), .RX0_RELEASE(rel0),
    .RX1_RELEASE(rel1), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .IRQ(irq));
  can_rx_path_model can_rx_path_model_i (.clk(clk), .srst(srst),
    .rel0(rel0), .rel1(rel1), .store0(st0), .store1(st1));
  task automatic cmp(input string n, input logic [33:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // sampled at the falling edge, where handshake signals are settled
  always @(negedge clk) begin
    if (bvalid && bready)
      cmp("bresp", 34'(bq.pop_front()), 34'(bresp));
    if (rvalid && rready)
      cmp("rdata", rq.pop_front(), {rresp, rdata});
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic ta, tw, tb;
    bq.push_back(r);
    tb = 0;
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic ta, tr;
    rq.push_back({r, d});
    tr = 0;
    @(posedge clk);
    araddr <= ad;
    {arvalid, rready} <= 2'h3;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic ck_irq(input logic e);
    @(negedge clk);
    cmp("irq", 34'(e), 34'(irq));
  endtask
  // release, then let the self-clearing bit settle
  task automatic rel(input logic [7:0] ad);
    wr(ad, 32'h20);
    repeat (3) @(posedge clk);
  endtask
  // whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  // both fifos walk the same path: fill, overrun, flags, drain
  initial begin
    void'($urandom(47142));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(RXF0_OFFSET, 0);
    rd(RXF1_OFFSET, 0);
    rd(IRQ_EN_OFFSET, 0);
    for (int f = 0; f < 2; f++) begin
      a = f ? RXF1_OFFSET : RXF0_OFFSET;
      s = 3 * f;
      wr(IRQ_EN_OFFSET, 32'h1 << (PEND0_EN_BIT + s));
      ck_irq(0);
      for (int i = 1; i < 4; i++) begin
        can_rx_path_model_i.store(f);
        rd(a, 32'(i) | (32'(i == 3) << FULL_BIT));
      end
      ck_irq(1);
      wr(a, $urandom & 32'hffffffc7);
      can_rx_path_model_i.store(f);
      rd(a, 32'h1b);
      wr(IRQ_EN_OFFSET, 32'h1 << (OVR0_EN_BIT + s));
      ck_irq(1);
      wr(a, 32'h10);
      ck_irq(0);
      wr(IRQ_EN_OFFSET, 32'h1 << (FULL0_EN_BIT + s));
      ck_irq(1);
      rel(a);
      rd(a, 32'h0a);
      wr(a, 32'h08);
      ck_irq(0);
      rel(a);
      rel(a);
      rel(a);
      rd(a, 0);
      cmp("released", 3, 34'(can_rx_path_model_i.rel_n[f]));
    end
    rd(IRQ_STS_OFFSET, 32'h3f);
    wr(IRQ_CLR_OFFSET, 32'h3f);
    rd(IRQ_STS_OFFSET, 0);
    rd(IRQ_EN_OFFSET, 32'h1 << FULL1_EN_BIT);
    wr(8'h30, $urandom, RESP_SLVERR);
    rd(8'h30, 0, RESP_SLVERR);
    report_and_stop;
  end
endmodule // can_rx_fifo_status_tb
`default_nettype wire
